/* hdl/awm_top.v */
// Purpose: Window alert monitor around an external 8-bit converter
// Assumes: Converter answers conv_start with one conv_done pulse on pclk
// Notes: Registers reachable over the two-wire bus and over APB
//
// Design decisions made here: the APB interface to the registers and the register addresses.
`timescale 1ns/1ns
`include "awm_defines.vh"
module awm_top #(
  parameter HAS_ADDR_PINS = 1,
  parameter [15:0] CYCLE_BASE = `AWM_CYCLE_BASE
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  input wire scl_in,
  input wire sda_in,
  output wire sda_out,
  output wire sda_oe,
  input wire [1:0] addr_select_low_pin,
  input wire [1:0] addr_select_high_pin,
  output reg conv_start,
  input wire conv_done,
  input wire [7:0] conv_data,
  output wire osc_en,
  output reg alert_out,
  output wire high_speed_bus_mode
);
  reg [3:0] pin_s1_ff;
  reg [3:0] pin_s2_ff;
  reg [7:0] cfg_ff;
  reg [7:0] low_ff;
  reg [7:0] high_ff;
  reg [7:0] hyst_ff;
  reg [7:0] min_ff;
  reg [7:0] max_ff;
  reg [7:0] result_ff;
  reg over_ff;
  reg under_ff;
  reg busy_ff;
  reg [15:0] timer_ff;
  reg [6:0] own_addr;
  reg [15:0] i2c_word;
  reg [15:0] apb_word;
  wire [2:0] ptr;
  wire i2c_wr;
  wire [7:0] i2c_data;
  wire rd_start;
  wire map_ok;
  wire apb_wr;
  wire w_en;
  wire [2:0] w_idx;
  wire [7:0] w_data;
  wire [2:0] cycle_code;
  wire auto_mode;
  wire [15:0] interval;
  wire tick;
  wire start_req;
  wire alert;
  wire hold;
  wire set_over;
  wire set_under;
  wire aclr_over;
  wire aclr_under;
  wire wclr_over;
  wire wclr_under;
  wire nxt_over;
  wire nxt_under;
  wire alert_act;
  wire nxt_alert;

  // Select pins come from outside; two flops before any decode
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_s1_ff <= 4'h5;
      pin_s2_ff <= 4'h5;
    end else begin
      pin_s1_ff <= {addr_select_high_pin, addr_select_low_pin};
      pin_s2_ff <= pin_s1_ff;
    end
  end

  always @* begin
    own_addr = `AWM_ADDR_FIXED;
    if (HAS_ADDR_PINS != 0) begin
      case (pin_s2_ff[3:2])
        `AWM_PIN_GND: own_addr = `AWM_ADDR_HI_GND;
        `AWM_PIN_SUPPLY: own_addr = `AWM_ADDR_HI_SUPPLY;
        default: own_addr = `AWM_ADDR_HI_FLOAT;
      endcase
      case (pin_s2_ff[1:0])
        `AWM_PIN_GND: own_addr = own_addr | 7'h01;
        `AWM_PIN_SUPPLY: own_addr = own_addr | 7'h02;
        default: own_addr = own_addr;
      endcase
    end
  end

  awm_i2c_target u_i2c (
    .pclk(pclk),
    .presetn(presetn),
    .scl_in(scl_in),
    .sda_in(sda_in),
    .own_addr(own_addr),
    .rd_word(i2c_word),
    .sda_oe_ff(sda_oe),
    .ptr_ff(ptr),
    .wr_ff(i2c_wr),
    .wr_data_ff(i2c_data),
    .rd_start_ff(rd_start),
    .hs_ff(high_speed_bus_mode)
  );

  // Open drain: only ever pulls low
  assign sda_out = 1'b0;

  assign alert = over_ff | under_ff;

  // Bus view: 8-bit registers ride in the upper byte, sent first
  always @* begin
    case (ptr)
      `AWM_REG_RESULT: i2c_word = {alert & cfg_ff[`AWM_CFG_FLAG_EN], 3'h0, result_ff, 4'h0};
      `AWM_REG_STATUS: i2c_word = {6'h00, over_ff, under_ff, 8'h00};
      `AWM_REG_CONFIG: i2c_word = {cfg_ff, 8'h00};
      `AWM_REG_LOW: i2c_word = {low_ff, 8'h00};
      `AWM_REG_HIGH: i2c_word = {high_ff, 8'h00};
      `AWM_REG_HYST: i2c_word = {hyst_ff, 8'h00};
      `AWM_REG_MIN: i2c_word = {min_ff, 8'h00};
      `AWM_REG_MAX: i2c_word = {max_ff, 8'h00};
      default: i2c_word = 16'h0000;
    endcase
  end

  // APB view: narrow registers sit in the low bits
  always @* begin
    case (paddr[4:2])
      `AWM_REG_RESULT: apb_word = {alert & cfg_ff[`AWM_CFG_FLAG_EN], 3'h0, result_ff, 4'h0};
      `AWM_REG_STATUS: apb_word = {14'h0000, over_ff, under_ff};
      `AWM_REG_CONFIG: apb_word = {8'h00, cfg_ff};
      `AWM_REG_LOW: apb_word = {8'h00, low_ff};
      `AWM_REG_HIGH: apb_word = {8'h00, high_ff};
      `AWM_REG_HYST: apb_word = {8'h00, hyst_ff};
      `AWM_REG_MIN: apb_word = {8'h00, min_ff};
      `AWM_REG_MAX: apb_word = {8'h00, max_ff};
      default: apb_word = 16'h0000;
    endcase
  end

  // Two-wire writes win a collision; APB simply waits one cycle
  assign map_ok = (paddr[7:5] == 3'h0) && (paddr[1:0] == 2'h0);
  assign pready = ~i2c_wr;
  assign pslverr = psel & penable & ~map_ok;
  assign apb_wr = psel & penable & pwrite & pready & map_ok;
  assign w_en = i2c_wr | apb_wr;
  assign w_idx = i2c_wr ? ptr : paddr[4:2];
  assign w_data = i2c_wr ? i2c_data : pwdata[7:0];

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (psel && !pwrite && map_ok) begin
      prdata <= {16'h0000, apb_word};
    end else if (psel && !penable) begin
      prdata <= 32'h00000000;
    end
  end

  // Automatic conversion timing
  assign cycle_code = cfg_ff[7:5];
  assign auto_mode = (cycle_code != 3'h0);
  assign interval = CYCLE_BASE << (cycle_code - 3'h1);
  assign tick = auto_mode && (timer_ff >= interval - 16'h0001);
  // Single-shot mode converts when the result register is addressed for reading over the two-wire bus
  assign start_req = ~busy_ff & (tick | (~auto_mode & rd_start & (ptr == `AWM_REG_RESULT)));
  // Oscillator never drops between automatic conversions
  assign osc_en = auto_mode | busy_ff;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_ff <= 16'h0000;
      busy_ff <= 1'b0;
      conv_start <= 1'b0;
    end else begin
      conv_start <= start_req;
      if (!auto_mode || tick) begin
        timer_ff <= 16'h0000;
      end else begin
        timer_ff <= timer_ff + 16'h0001;
      end
      if (start_req) begin
        busy_ff <= 1'b1;
      end else if (conv_done) begin
        busy_ff <= 1'b0;
      end
    end
  end

  // Limit checks look only at finished samples, never the live input
  assign hold = cfg_ff[`AWM_CFG_HOLD];
  assign set_over = conv_done & (conv_data > high_ff);
  assign set_under = conv_done & (conv_data < low_ff);
  // Nine-bit sums avoid wrap when limits sit near the rails
  assign aclr_over = conv_done & ~hold & (({1'b0, conv_data} + {1'b0, hyst_ff}) < {1'b0, high_ff});
  assign aclr_under = conv_done & ~hold & ({1'b0, conv_data} > ({1'b0, low_ff} + {1'b0, hyst_ff}));
  assign wclr_over = w_en & (w_idx == `AWM_REG_STATUS) & w_data[`AWM_ST_OVER];
  assign wclr_under = w_en & (w_idx == `AWM_REG_STATUS) & w_data[`AWM_ST_UNDER];
  // A new violation beats a clear in the same cycle
  assign nxt_over = set_over | (over_ff & ~wclr_over & ~aclr_over);
  assign nxt_under = set_under | (under_ff & ~wclr_under & ~aclr_under);

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      over_ff <= 1'b0;
      under_ff <= 1'b0;
      result_ff <= 8'h00;
    end else begin
      over_ff <= nxt_over;
      under_ff <= nxt_under;
      if (conv_done) begin
        result_ff <= conv_data;
      end
    end
  end

  // Writable registers; limits and records load whole bytes
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_ff <= `AWM_RST_CONFIG;
      low_ff <= `AWM_RST_LOW;
      high_ff <= `AWM_RST_HIGH;
      hyst_ff <= `AWM_RST_HYST;
    end else if (w_en) begin
      case (w_idx)
        `AWM_REG_CONFIG: cfg_ff <= w_data & `AWM_CFG_MASK;
        `AWM_REG_LOW: low_ff <= w_data;
        `AWM_REG_HIGH: high_ff <= w_data;
        `AWM_REG_HYST: hyst_ff <= w_data;
        default: cfg_ff <= cfg_ff;
      endcase
    end
  end

  // Records track extremes in automatic mode; a controller write is the only reset besides presetn
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      min_ff <= `AWM_RST_MIN;
      max_ff <= `AWM_RST_MAX;
    end else begin
      if (w_en && w_idx == `AWM_REG_MIN) begin
        min_ff <= w_data;
      end else if (auto_mode && conv_done && conv_data < min_ff) begin
        min_ff <= conv_data;
      end
      if (w_en && w_idx == `AWM_REG_MAX) begin
        max_ff <= w_data;
      end else if (auto_mode && conv_done && conv_data > max_ff) begin
        max_ff <= conv_data;
      end
    end
  end

  // Alert pin, registered so it cannot glitch on config writes
  assign alert_act = alert & cfg_ff[`AWM_CFG_PIN_EN];
  assign nxt_alert = cfg_ff[`AWM_CFG_POL] ? alert_act : ~alert_act;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      alert_out <= 1'b1;
    end else begin
      alert_out <= nxt_alert;
    end
  end
endmodule

/* hdl/awm_defines.vh */
// Purpose: Constants of the window alert monitor
// Assumes: Register index is the pointer value, byte address is index times four
// Notes: Timing counts are pclk cycles
// Operation
// - Seven-bit target address decoded from two tri-level select pins.
// - Without select pins the target address is fixed at 1010100.
// - Every finished conversion is compared with high and low limits.
// - Result above high limit sets the over-range flag.
// - Result below low limit sets the under-range flag.
// - Flag enable forces result register MSB high during an alert.
// - Pin enable drives the alert output active during an alert.
// - Alert output active low with polarity zero, active high with one.
// - Writing one to the over-range flag clears it.
// - Without hold, over-range clears below high limit minus hysteresis.
// - Writing one to the under-range flag clears it.
// - Without hold, under-range clears above low limit plus hysteresis.
// - A cleared flag rises again at the next violating conversion.
// - Limits are checked only on sampled conversion results.
// - Nonzero cycle-time bits start automatic conversions at the selected rate.
// - Oscillator enable stays on throughout automatic mode.
// - Automatic results update result and status without any bus read.
// - Automatic results update the minimum and maximum records.
// - Minimum and maximum records hold until written by the controller.
// - First data byte of every write loads the register pointer.
// - Write is pointer, upper byte, optional lower byte, each acknowledged.
// - Refuse high-speed master code, then high-speed mode until stop.
`ifndef AWM_DEFINES_VH
`define AWM_DEFINES_VH
`define AWM_REG_RESULT 3'h0
`define AWM_REG_STATUS 3'h1
`define AWM_REG_CONFIG 3'h2
`define AWM_REG_LOW 3'h3
`define AWM_REG_HIGH 3'h4
`define AWM_REG_HYST 3'h5
`define AWM_REG_MIN 3'h6
`define AWM_REG_MAX 3'h7
`define AWM_ST_OVER 1
`define AWM_ST_UNDER 0
`define AWM_CFG_HOLD 4
`define AWM_CFG_FLAG_EN 3
`define AWM_CFG_PIN_EN 2
`define AWM_CFG_POL 0
`define AWM_CFG_MASK 8'hfd
`define AWM_RST_CONFIG 8'h00
`define AWM_RST_LOW 8'h00
`define AWM_RST_HIGH 8'hff
`define AWM_RST_HYST 8'h00
`define AWM_RST_MIN 8'hff
`define AWM_RST_MAX 8'h00
`define AWM_PIN_GND 2'h0
`define AWM_PIN_FLOAT 2'h1
`define AWM_PIN_SUPPLY 2'h2
`define AWM_ADDR_FIXED 7'h54
`define AWM_ADDR_HI_FLOAT 7'h50
`define AWM_ADDR_HI_GND 7'h54
`define AWM_ADDR_HI_SUPPLY 7'h58
`define AWM_HS_CODE 5'h01
`define AWM_CYCLE_BASE 16'h0020
`endif

/* hdl/awm_i2c_target.v */
// Purpose: Two-wire bus target engine with pointer and byte strobes
// Assumes: Bus clock well below a quarter of pclk
// Notes: High-speed mode is tracked only; sampling limits the real rate
`timescale 1ns/1ns
`include "awm_defines.vh"
module awm_i2c_target (
  input wire pclk,
  input wire presetn,
  input wire scl_in,
  input wire sda_in,
  input wire [6:0] own_addr,
  input wire [15:0] rd_word,
  output reg sda_oe_ff,
  output reg [2:0] ptr_ff,
  output reg wr_ff,
  output reg [7:0] wr_data_ff,
  output reg rd_start_ff,
  output reg hs_ff
);
  localparam S_IDLE = 3'd0;
  localparam S_RX = 3'd1;
  localparam S_ACK = 3'd2;
  localparam S_TX = 3'd3;
  localparam S_RACK = 3'd4;
  reg scl_s1_ff, scl_s2_ff, scl_d_ff, sda_s1_ff, sda_s2_ff, sda_d_ff;
  reg [2:0] st_ff;
  reg [3:0] bit_ff;
  reg [7:0] sh_ff;
  reg is_addr_ff, is_read_ff, first_ff, lo_ff, cont_ff;
  wire scl_rise = scl_s2_ff & ~scl_d_ff;
  wire scl_fall = ~scl_s2_ff & scl_d_ff;
  wire start_c = scl_s2_ff & scl_d_ff & ~sda_s2_ff & sda_d_ff;
  wire stop_c = scl_s2_ff & scl_d_ff & sda_s2_ff & ~sda_d_ff;
  // lo_ff high means the lower byte goes out next
  wire [7:0] nxt_tx = lo_ff ? rd_word[7:0] : rd_word[15:8];
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {scl_s1_ff, scl_s2_ff, scl_d_ff, sda_s1_ff, sda_s2_ff, sda_d_ff} <= 6'h3f;
      st_ff <= S_IDLE;
      bit_ff <= 4'h0;
      sh_ff <= 8'h00;
      {is_addr_ff, is_read_ff, first_ff, lo_ff, cont_ff} <= 5'h00;
      sda_oe_ff <= 1'b0;
      ptr_ff <= 3'h0;
      wr_ff <= 1'b0;
      wr_data_ff <= 8'h00;
      rd_start_ff <= 1'b0;
      hs_ff <= 1'b0;
    end else begin
      {scl_s1_ff, scl_s2_ff, scl_d_ff} <= {scl_in, scl_s1_ff, scl_s2_ff};
      {sda_s1_ff, sda_s2_ff, sda_d_ff} <= {sda_in, sda_s1_ff, sda_s2_ff};
      wr_ff <= 1'b0;
      rd_start_ff <= 1'b0;
      if (stop_c) begin
        st_ff <= S_IDLE;
        sda_oe_ff <= 1'b0;
        hs_ff <= 1'b0;
      end else if (start_c) begin
        st_ff <= S_RX;
        bit_ff <= 4'h0;
        is_addr_ff <= 1'b1;
        sda_oe_ff <= 1'b0;
      end else begin
        case (st_ff)
          S_RX: begin
            if (scl_rise && bit_ff != 4'h8) begin
              sh_ff <= {sh_ff[6:0], sda_s2_ff};
              bit_ff <= bit_ff + 4'h1;
            end else if (scl_fall && bit_ff == 4'h8) begin
              if (is_addr_ff) begin
                is_addr_ff <= 1'b0;
                if (sh_ff[7:1] == own_addr) begin
                  sda_oe_ff <= 1'b1;
                  is_read_ff <= sh_ff[0];
                  rd_start_ff <= sh_ff[0];
                  first_ff <= 1'b1;
                  lo_ff <= 1'b0;
                  st_ff <= S_ACK;
                end else begin
                  hs_ff <= hs_ff | (sh_ff[7:3] == `AWM_HS_CODE);
                  st_ff <= S_IDLE;
                end
              end else begin
                sda_oe_ff <= 1'b1;
                st_ff <= S_ACK;
                first_ff <= 1'b0;
                if (first_ff) begin
                  ptr_ff <= sh_ff[2:0];
                end else begin
                  lo_ff <= ~lo_ff;
                  wr_ff <= ~lo_ff;
                  wr_data_ff <= sh_ff;
                end
              end
            end
          end
          S_ACK: begin
            if (scl_fall) begin
              bit_ff <= 4'h0;
              if (is_read_ff) begin
                sh_ff <= rd_word[15:8];
                sda_oe_ff <= ~rd_word[15];
                lo_ff <= 1'b1;
                st_ff <= S_TX;
              end else begin
                sda_oe_ff <= 1'b0;
                st_ff <= S_RX;
              end
            end
          end
          S_TX: begin
            if (scl_fall) begin
              bit_ff <= bit_ff + 4'h1;
              sh_ff <= {sh_ff[6:0], 1'b0};
              sda_oe_ff <= (bit_ff == 4'h7) ? 1'b0 : ~sh_ff[6];
              if (bit_ff == 4'h7) begin
                st_ff <= S_RACK;
              end
            end
          end
          S_RACK: begin
            if (scl_rise) begin
              cont_ff <= ~sda_s2_ff;
            end else if (scl_fall) begin
              bit_ff <= 4'h0;
              if (cont_ff) begin
                sh_ff <= nxt_tx;
                sda_oe_ff <= ~nxt_tx[7];
                lo_ff <= ~lo_ff;
                st_ff <= S_TX;
              end else begin
                st_ff <= S_IDLE;
              end
            end
          end
          default: st_ff <= S_IDLE;
        endcase
      end
    end
  end
endmodule

/* sim/awm_chk.sv */
// Purpose: Port checks of the window alert monitor
// Assumes: One pclk domain reset by presetn
// Notes: Data pin may only pull low
`timescale 1ns/1ns
module awm_chk #(
  parameter HAS_ADDR_PINS = 1,
  parameter [15:0] CYCLE_BASE = 16'h0020
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire sda_out,
  input wire sda_oe,
  input wire conv_start,
  input wire conv_done,
  input wire osc_en,
  input wire alert_out,
  input wire high_speed_bus_mode
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  wire bad = (paddr[7:5] != 3'h0) || (paddr[1:0] != 2'h0);
  wire wr_any = (psel && penable && pwrite) || !pready;
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_acc;
    psel && penable && pready;
  endsequence
  a_map_err: assert property (psel && penable && bad |-> pslverr)
    else $error("unmapped access without pslverr");
  a_map_ok: assert property (psel && penable && !bad |-> !pslverr)
    else $error("pslverr on mapped access");
  a_err_zero: assert property (s_setup ##1 (s_acc and (!pwrite && pslverr)) |-> prdata == 32'h0)
    else $error("unmapped read data not zero");
  a_data_hold: assert property (s_acc ##1 !psel |-> $stable(prdata))
    else $error("read data moved after transfer");
  a_ready_stall: assert property (!pready |=> pready)
    else $error("ready held low too long");
  a_start_pulse: assert property (conv_start |=> !conv_start)
    else $error("conversion start longer than one cycle");
  a_osc_busy: assert property (conv_start |-> osc_en ##1 osc_en)
    else $error("oscillator off during conversion");
  a_sda_low: assert property (sda_out == 1'b0)
    else $error("data pin driven high");
  a_alert_cause: assert property ($changed(alert_out) |-> $past(conv_done) || $past(conv_done, 2)
    || $past(conv_done, 3) || $past(wr_any) || $past(wr_any, 2) || $past(wr_any, 3))
    else $error("alert moved without conversion or write");
  a_hs_nack: assert property ($rose(high_speed_bus_mode) |-> !sda_oe [*8])
    else $error("master code acknowledged");
endmodule

/* sim/awm_i2c_host.sv */
// Purpose: Two-wire controller model
// Assumes: Pull-ups on both lines, 320 ns bit
// Notes: Clock stands high between frames
`timescale 1ns/1ns
module awm_i2c_host (
  input wire pclk,
  input wire sda_in,
  output reg scl_ff = 1'b1,
  output reg sda_low_ff = 1'b0
);
  task q2;
    repeat (2) @(posedge pclk);
  endtask
  // Clock low first so a repeated start never looks like a stop
  task start;
    begin
      scl_ff <= 1'b0;
      q2;
      sda_low_ff <= 1'b0;
      q2;
      scl_ff <= 1'b1;
      q2;
      sda_low_ff <= 1'b1;
      q2;
    end
  endtask
  task stop;
    begin
      scl_ff <= 1'b0;
      q2;
      sda_low_ff <= 1'b1;
      q2;
      scl_ff <= 1'b1;
      q2;
      sda_low_ff <= 1'b0;
      q2;
    end
  endtask
  task bitx(input b, output r);
    begin
      scl_ff <= 1'b0;
      q2;
      sda_low_ff <= !b;
      q2;
      scl_ff <= 1'b1;
      q2;
      @(negedge pclk);
      r = sda_in;
      q2;
    end
  endtask
  task wbyte(input [7:0] d, output ack);
    reg r;
    integer i;
    begin
      for (i = 7; i >= 0; i = i - 1) bitx(d[i], r);
      bitx(1'b1, r);
      ack = !r;
    end
  endtask
  task rbyte(input more, output [7:0] d);
    reg r;
    integer i;
    begin
      for (i = 0; i < 8; i = i + 1) begin
        bitx(1'b1, r);
        d = {d[6:0], r};
      end
      bitx(!more, r);
    end
  endtask
endmodule

/* sim/awm_top_tb.sv */
// Purpose: Self-checking bench of the window alert monitor
// Assumes: Converter answers start one cycle later
// Notes: Short cycle base keeps automatic runs brief
`timescale 1ns/1ns
module awm_top_tb;
  reg pclk, presetn, psel, penable, pwrite, conv_done, e, ack;
  reg [7:0] paddr, conv_data, conv_val, d1, d2;
  reg [31:0] pwdata, q;
  reg [1:0] pin_lo, pin_hi;
  wire [31:0] prdata;
  wire pready, pslverr, scl, sda_low, sda_out, sda_oe, conv_start, osc_en, alert_out, hs;
  wire sda_w = !(sda_low || sda_oe);
  integer errors, tests_run;
  awm_top #(.CYCLE_BASE(16'h0004)) u_awm_top (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .scl_in(scl), .sda_in(sda_w), .sda_out(sda_out),
    .sda_oe(sda_oe), .addr_select_low_pin(pin_lo), .addr_select_high_pin(pin_hi),
    .conv_start(conv_start), .conv_done(conv_done), .conv_data(conv_data), .osc_en(osc_en),
    .alert_out(alert_out), .high_speed_bus_mode(hs));
  awm_i2c_host u_awm_i2c_host (.pclk(pclk), .sda_in(sda_w), .scl_ff(scl), .sda_low_ff(sda_low));
  // Data outside the pulse is inverted so stale values are not mistaken for results
  always @(posedge pclk) begin
    conv_done <= conv_start;
    conv_data <= conv_start ? conv_val : ~conv_val;
  end
  task chk(input [31:0] s, input [31:0] x);
    begin
      tests_run = tests_run + 1;
      if (s !== x) begin
        errors = errors + 1;
        $display("mismatch at %0t: got %h want %h", $time, s, x);
      end
    end
  endtask
  task idle(input integer n);
    repeat (n) @(posedge pclk);
  endtask
  task apb(input w, input [7:0] a, input [31:0] d);
    begin
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  task wr(input [2:0] i, input [7:0] d);
    apb(1'b1, {3'h0, i, 2'h0}, {24'h0, d});
  endtask
  task rd(input [2:0] i);
    apb(1'b0, {3'h0, i, 2'h0}, 32'h0);
  endtask
  task set_in(input [7:0] v);
    begin
      conv_val <= v;
      idle(24);
    end
  endtask
  task t_regs;
    reg [47:0] rv;
    integer i;
    begin
      rv = 48'h0000ff00ff00;
      for (i = 2; i < 8; i = i + 1) begin
        rd(i[2:0]);
        chk(q, {24'h0, rv[63-8*i -: 8]});
      end
      apb(1'b0, 8'h20, 32'h0);
      chk({e, q[30:0]}, 32'h80000000);
      apb(1'b1, 8'h06, 32'hff);
      chk({31'h0, e}, 32'h1);
    end
  endtask
  task t_window;
    reg [63:0] vals;
    reg [15:0] sts;
    reg [7:0] v;
    reg [1:0] s;
    integer i;
    begin
      vals = 64'hc0c1b0af403f5051;
      sts = 16'h2814;
      wr(3, 8'h40);
      wr(4, 8'hc0);
      wr(5, 8'h10);
      wr(2, 8'h2c);
      idle(8);
      chk({31'h0, osc_en}, 32'h1);
      for (i = 0; i < 8; i = i + 1) begin
        v = vals[63-8*i -: 8];
        s = sts[15-2*i -: 2];
        set_in(v);
        rd(1);
        chk(q, {30'h0, s});
        rd(0);
        chk(q, {16'h0, s != 2'h0, 3'h0, v, 4'h0});
        chk({31'h0, alert_out}, {31'h0, s == 2'h0});
      end
      wr(2, 8'h2d);
      set_in(8'hd0);
      chk({31'h0, alert_out}, 32'h1);
      wr(2, 8'h2c);
      set_in(8'h80);
    end
  endtask
  task t_clear;
    begin
      set_in(8'hd0);
      wr(1, 8'h00);
      rd(1);
      chk(q, 32'h2);
      wr(2, 8'h0c);
      idle(8);
      wr(1, 8'h02);
      rd(1);
      chk(q, 32'h0);
      wr(2, 8'h2c);
      idle(24);
      rd(1);
      chk(q, 32'h2);
      set_in(8'h30);
      wr(2, 8'h0c);
      idle(8);
      wr(1, 8'h01);
      rd(1);
      chk(q, 32'h0);
      wr(2, 8'h2c);
      idle(24);
      rd(1);
      chk(q, 32'h1);
      wr(2, 8'h3c);
      set_in(8'hd0);
      set_in(8'h80);
      rd(1);
      chk(q, 32'h3);
      wr(1, 8'h03);
      idle(8);
      rd(1);
      chk(q, 32'h0);
      wr(2, 8'h2c);
    end
  endtask
  task t_minmax;
    begin
      set_in(8'h70);
      wr(6, 8'hff);
      wr(7, 8'h00);
      set_in(8'h20);
      set_in(8'h90);
      set_in(8'h50);
      rd(6);
      chk(q, 32'h20);
      rd(7);
      chk(q, 32'h90);
      wr(2, 8'h0c);
      set_in(8'h05);
      rd(6);
      chk(q, 32'h20);
      chk({31'h0, osc_en}, 32'h0);
    end
  endtask
  task t_rate;
    integer c, k, n;
    begin
      for (c = 1; c < 5; c = c + 1) begin
        wr(2, {c[2:0], 5'h0c});
        idle(40);
        n = 0;
        for (k = 0; k < 128; k = k + 1) begin
          @(negedge pclk);
          n = n + conv_start;
        end
        chk(n, 32 >> (c - 1));
      end
      wr(2, 8'h0c);
    end
  endtask
  task t_bus;
    reg [32:0] tab;
    reg [10:0] ent;
    integer i;
    begin
      tab = {2'h1, 2'h1, 7'h50, 2'h0, 2'h0, 7'h55, 2'h2, 2'h2, 7'h5a};
      for (i = 0; i < 3; i = i + 1) begin
        ent = tab[32-11*i -: 11];
        pin_hi <= ent[10:9];
        pin_lo <= ent[8:7];
        idle(6);
        u_awm_i2c_host.start;
        u_awm_i2c_host.wbyte({ent[6:0], 1'b0}, ack);
        chk({31'h0, ack}, 32'h1);
        u_awm_i2c_host.wbyte(8'h05, ack);
        u_awm_i2c_host.wbyte({1'b0, ent[6:0]}, ack);
        u_awm_i2c_host.wbyte(8'hff, ack);
        u_awm_i2c_host.stop;
        chk({31'h0, ack}, 32'h1);
        rd(5);
        chk(q, {25'h0, ent[6:0]});
        u_awm_i2c_host.start;
        u_awm_i2c_host.wbyte({ent[6:0], 1'b1}, ack);
        u_awm_i2c_host.rbyte(1'b1, d1);
        u_awm_i2c_host.rbyte(1'b0, d2);
        u_awm_i2c_host.stop;
        chk({16'h0, d1, d2}, {17'h0, ent[6:0], 8'h0});
        u_awm_i2c_host.start;
        u_awm_i2c_host.wbyte({ent[6:0] ^ 7'h01, 1'b0}, ack);
        u_awm_i2c_host.stop;
        chk({31'h0, ack}, 32'h0);
      end
      // Pointer 0 read in single-shot mode converts first; under flag still set
      u_awm_i2c_host.start;
      u_awm_i2c_host.wbyte({ent[6:0], 1'b0}, ack);
      u_awm_i2c_host.wbyte(8'h00, ack);
      u_awm_i2c_host.start;
      u_awm_i2c_host.wbyte({ent[6:0], 1'b1}, ack);
      u_awm_i2c_host.rbyte(1'b1, d1);
      u_awm_i2c_host.rbyte(1'b0, d2);
      u_awm_i2c_host.stop;
      chk({16'h0, d1, d2}, 32'h8050);
      u_awm_i2c_host.start;
      u_awm_i2c_host.wbyte(8'h08, ack);
      chk({30'h0, ack, hs}, 32'h1);
      u_awm_i2c_host.start;
      u_awm_i2c_host.wbyte({ent[6:0], 1'b0}, ack);
      chk({30'h0, ack, hs}, 32'h3);
      u_awm_i2c_host.stop;
      idle(4);
      chk({31'h0, hs}, 32'h0);
    end
  endtask
  task test_done;
    begin
      $display("errors %0d tests_run %0d", errors, tests_run);
      if (errors == 0 && tests_run > 0)
        $display("[ PASS ]");
      else
        $display("[ FAIL ]");
      $finish;
    end
  endtask
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  initial begin
    {presetn, psel, penable, pwrite} = 4'h0;
    {paddr, pwdata, conv_val} = 48'h0;
    pin_lo = 2'h1;
    pin_hi = 2'h1;
    errors = 0;
    tests_run = 0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    idle(4);
    t_regs;
    t_window;
    t_clear;
    t_minmax;
    t_rate;
    t_bus;
    test_done;
  end
  // Whole run needs about 4000 cycles
  initial begin
    idle(60000);
    errors = errors + 1;
    test_done;
  end
endmodule
bind awm_top awm_chk #(.HAS_ADDR_PINS(HAS_ADDR_PINS), .CYCLE_BASE(CYCLE_BASE)) u_awm_chk (.pclk, .presetn,
  .psel, .penable, .pwrite, .paddr, .prdata, .pready, .pslverr, .sda_out, .sda_oe, .conv_start,
  .conv_done, .osc_en, .alert_out, .high_speed_bus_mode);
